// File: src/fbd_top.sv
// Purpose: flash array base decode, access gating and reset configuration
// Assumes: all inputs synchronous to CLK_SYS; one access in flight at a time
// Notes: the flash array itself sits outside; this block steers and gates it
`default_nettype none
module fbd_top
  import fbd_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic CORE_CR_WR,
  input wire logic [31:0] CORE_CR_WDATA,
  input wire logic DBG_WR,
  input wire logic DBG_RD,
  input wire logic [31:0] DBG_WDATA,
  output logic [31:0] DBG_RDATA,
  input wire logic RESET_CONFIG_PIN,
  input wire logic [2:0] BOOT_DATA,
  input wire logic [1:0] MASTER_MODE,
  input wire logic [31:0] PERIPHERAL_BASE_REGISTER,
  input wire logic REQ,
  input wire logic [31:0] REQ_ADDR,
  input wire logic REQ_WRITE,
  input wire logic REQ_PROG,
  input wire logic REQ_SUPERVISOR_ACCESS_WORD,
  input wire logic REQ_CODE,
  input wire logic REQ_CPU_SPACE,
  input wire logic REQ_IS_CORE,
  input wire logic [31:0] FLASH_RDATA,
  output logic FLASH_SEL,
  output logic FLASH_ODD,
  output logic [17:0] FLASH_WORD,
  output logic FLASH_WE,
  output logic FLASH_CFG_RD,
  output logic [31:0] FLASH_CFG_ADDR,
  output logic ACK,
  output logic [31:0] RDATA,
  output logic ACCESS_ERR,
  output logic NON_FLASH,
  output logic PROT_VIOL,
  output logic SECURED,
  output logic CFG_READY
);
  typedef struct packed {
    fbd_state_t st;
    logic [31:0] base;
    logic strap_taken;
    logic [1:0] wait_cnt;
    logic [31:0] dbg_rdata;
    logic sel;
    logic odd;
    logic [17:0] word;
    logic we;
    logic ack;
    logic [31:0] rdata;
    logic aerr;
    logic nonflash;
    logic pviol;
    logic secured;
    logic cfg_ready;
  } fbd_state_s_t;
  fbd_state_s_t s_q, s_d;

  fbd_cfg_if cfg ();

  // configuration walk; the loader only sees the array word it asks for
  fbd_cfg_loader u_loader (
    .clk(CLK_SYS),
    .srst(SRST),
    .cfg(cfg.loader)
  );
  assign cfg.word = FLASH_RDATA;

  // address decode terms
  logic [31:0] direct_ofs;
  logic [31:0] back_ofs;
  logic hit_direct;
  logic hit_back;
  logic [4:0] mask_vec;
  logic [4:0] type_vec;
  logic masked;
  logic [31:0] ofs;
  logic [4:0] sector;
  logic sec_prot;
  logic sec_supervisor_access_word_only;
  logic sec_no_code;
  logic strap_valid;

  // base match on the 512K boundary and the backdoor window
  always_comb begin
    direct_ofs = REQ_ADDR - {s_q.base[FBD_BA_HI:FBD_BA_LO], 19'd0};
    back_ofs = REQ_ADDR - (PERIPHERAL_BASE_REGISTER + FBD_BACKDOOR_OFS);
    hit_direct = (REQ_ADDR[FBD_BA_HI:FBD_BA_LO] == s_q.base[FBD_BA_HI:FBD_BA_LO])
      && s_q.base[FBD_VALID_BIT];
    hit_back = (back_ofs < FBD_BACKDOOR_SPAN);
    mask_vec = s_q.base[FBD_MASK_HI:FBD_MASK_LO];
    type_vec = 5'd0;
    if (REQ_CPU_SPACE) begin
      type_vec[FBD_AT_CPU] = 1'b1;
    end else if (REQ_SUPERVISOR_ACCESS_WORD) begin
      type_vec[REQ_CODE ? FBD_AT_SC : FBD_AT_SD] = 1'b1;
    end else begin
      type_vec[REQ_CODE ? FBD_AT_UC : FBD_AT_UD] = 1'b1;
    end
    masked = |(mask_vec & type_vec);
    ofs = (hit_direct && REQ_IS_CORE) ? direct_ofs : back_ofs;
    sector = ofs[17:13];
  end

  // per-sector protection, seeded from the configuration region
  always_comb begin
    sec_prot = !cfg.prot[sector];
    sec_supervisor_access_word_only = !cfg.supervisor_access_word[sector];
    sec_no_code = !cfg.data[sector];
  end

  // boot straps decide the valid bit
  always_comb begin
    strap_valid = 1'b1;
    if (RESET_CONFIG_PIN) begin
      strap_valid = (BOOT_DATA == FBD_BOOT_SINGLE)
        || (BOOT_DATA == FBD_BOOT_MASTER && MASTER_MODE == FBD_MMODE_INT);
    end
  end

  // next state: register writes, access sequencing, reset configuration
  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.aerr = 1'b0;
    s_d.pviol = 1'b0;
    s_d.nonflash = 1'b0;
    s_d.we = 1'b0;
    s_d.sel = 1'b0;
    // straps caught once the reset releases; only the valid bit moves
    if (!s_q.strap_taken) begin
      s_d.strap_taken = 1'b1;
      s_d.base[FBD_VALID_BIT] = strap_valid;
    end
    // security check follows the configuration load
    if (cfg.done && !s_q.cfg_ready) begin
      s_d.cfg_ready = 1'b1;
      s_d.secured = (cfg.sec != FBD_SEC_OPEN);
      if (cfg.sec != FBD_SEC_OPEN) begin
        s_d.base[FBD_VALID_BIT] = 1'b1;
      end
    end
    // core and debug writes; debug has priority when both land together
    if (DBG_WR) begin
      s_d.base = DBG_WDATA & FBD_DEFINED_BITS;
    end else if (CORE_CR_WR) begin
      s_d.base = CORE_CR_WDATA & FBD_DEFINED_BITS;
    end
    if (DBG_RD) begin
      s_d.dbg_rdata = s_q.base & FBD_DEFINED_BITS;
    end
    case (s_q.st)
      FBD_LOAD: begin
        if (cfg.done) begin
          s_d.st = FBD_RUN;
        end
      end
      FBD_RUN: begin
        if (REQ) begin
          if (masked || !(hit_direct || hit_back) || (!REQ_IS_CORE && !hit_back)) begin
            s_d.nonflash = 1'b1;
            s_d.ack = 1'b1;
          end else if (REQ_WRITE && s_q.base[FBD_WP_BIT]) begin
            s_d.aerr = 1'b1;
            s_d.ack = 1'b1;
          end else if ((REQ_PROG && sec_prot) || (!REQ_SUPERVISOR_ACCESS_WORD && sec_supervisor_access_word_only)
            || (REQ_CODE && sec_no_code)) begin
            s_d.pviol = 1'b1;
            s_d.ack = 1'b1;
          end else if (REQ_WRITE && REQ_IS_CORE && !hit_back) begin
            s_d.aerr = 1'b1;
            s_d.ack = 1'b1;
          end else if (ofs > FBD_BLOCK0_LAST) begin
            s_d.nonflash = 1'b1;
            s_d.ack = 1'b1;
          end else begin
            s_d.sel = 1'b1;
            s_d.odd = ofs[FBD_BANK_BIT];
            s_d.word = ofs[19:2];
            s_d.we = REQ_WRITE;
            if (!REQ_WRITE) begin
              // array data shows one cycle after the select; the alias adds its penalty
              s_d.wait_cnt = (hit_back && !(hit_direct && REQ_IS_CORE))
                ? 2'(FBD_BACKDOOR_EXTRA + 1) : 2'd1;
              s_d.st = FBD_WAIT;
            end else begin
              s_d.ack = 1'b1;
            end
          end
        end
      end
      FBD_WAIT: begin
        if (s_q.wait_cnt == 2'd1) begin
          s_d.ack = 1'b1;
          s_d.st = FBD_RUN;
        end
        s_d.wait_cnt = s_q.wait_cnt - 2'd1;
      end
      default: begin
        s_d.st = FBD_LOAD;
      end
    endcase
    if (s_q.ack == 1'b0 && s_d.ack) begin
      s_d.rdata = FLASH_RDATA;
    end
  end

  // one register stage for all state; base moves only on register writes and the valid bit
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      s_q.st <= FBD_LOAD;
      s_q.base <= FBD_BASE_RESET;
      s_q.strap_taken <= 1'b0;
      s_q.wait_cnt <= 2'd0;
      s_q.dbg_rdata <= 32'h0000_0000;
      s_q.sel <= 1'b0;
      s_q.odd <= 1'b0;
      s_q.word <= 18'h0_0000;
      s_q.we <= 1'b0;
      s_q.ack <= 1'b0;
      s_q.rdata <= 32'h0000_0000;
      s_q.aerr <= 1'b0;
      s_q.nonflash <= 1'b0;
      s_q.pviol <= 1'b0;
      s_q.secured <= 1'b0;
      s_q.cfg_ready <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // configuration fetch address rides on the direct window from zero
  logic cfg_rd_q;
  logic [31:0] cfg_addr_q;
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      cfg_rd_q <= 1'b0;
      cfg_addr_q <= 32'h0000_0000;
    end else begin
      cfg_rd_q <= cfg.fetch;
      cfg_addr_q <= cfg.ofs;
    end
  end

  assign DBG_RDATA = s_q.dbg_rdata;
  assign FLASH_SEL = s_q.sel;
  assign FLASH_ODD = s_q.odd;
  assign FLASH_WORD = s_q.word;
  assign FLASH_WE = s_q.we;
  assign FLASH_CFG_RD = cfg_rd_q;
  assign FLASH_CFG_ADDR = cfg_addr_q;
  assign ACK = s_q.ack;
  assign RDATA = s_q.rdata;
  assign ACCESS_ERR = s_q.aerr;
  assign NON_FLASH = s_q.nonflash;
  assign PROT_VIOL = s_q.pviol;
  assign SECURED = s_q.secured;
  assign CFG_READY = s_q.cfg_ready;
endmodule
`default_nettype wire

// File: inc/fbd_pkg.sv
// Purpose: constants and types for the flash base address decode block
// Assumes: 40 MHz system clock, synchronous active-high reset
// Notes: the configuration region sits at fixed offsets above the array base
`default_nettype none
package fbd_pkg;
  // flash base register layout
  localparam int FBD_BA_HI = 31;
  localparam int FBD_BA_LO = 19;
  localparam int FBD_WP_BIT = 8;
  localparam int FBD_MASK_HI = 5;
  localparam int FBD_MASK_LO = 1;
  localparam int FBD_VALID_BIT = 0;
  localparam logic [31:0] FBD_DEFINED_BITS = 32'hFFF8_013F;
  localparam logic [31:0] FBD_BASE_RESET = 32'h0000_0000;
  // array geometry: two interleaved 32-bit blocks
  localparam logic [31:0] FBD_BLOCK0_LAST = 32'h0003_FFFF;
  localparam int FBD_BANK_BIT = 2;
  // backdoor alias above the peripheral base
  localparam logic [31:0] FBD_BACKDOOR_OFS = 32'h0400_0000;
  localparam logic [31:0] FBD_BACKDOOR_SPAN = 32'h0008_0000;
  localparam int FBD_BACKDOOR_EXTRA = 2;
  // configuration region
  localparam logic [31:0] FBD_CFG_KEY_OFS = 32'h0000_0400;
  localparam logic [31:0] FBD_CFG_PROT_OFS = 32'h0000_0408;
  localparam logic [31:0] FBD_CFG_SUPERVISOR_ACCESS_WORD_OFS = 32'h0000_040C;
  localparam logic [31:0] FBD_CFG_DATA_OFS = 32'h0000_0410;
  localparam logic [31:0] FBD_CFG_SEC_OFS = 32'h0000_0414;
  localparam int FBD_CFG_BYTES = 24;
  localparam int FBD_CFG_WORDS = 6;
  localparam logic [31:0] FBD_CFG_DEFAULT = 32'hFFFF_FFFF;
  // security word value that leaves the flash unsecured
  localparam logic [31:0] FBD_SEC_OPEN = 32'hFFFF_FFFF;
  // boot straps
  localparam logic [2:0] FBD_BOOT_SINGLE = 3'h6;
  localparam logic [2:0] FBD_BOOT_MASTER = 3'h7;
  localparam logic [1:0] FBD_MMODE_INT = 2'h0;
  // access type index into the mask field
  localparam int FBD_AT_CPU = 4;
  localparam int FBD_AT_SC = 3;
  localparam int FBD_AT_SD = 2;
  localparam int FBD_AT_UC = 1;
  localparam int FBD_AT_UD = 0;
  localparam logic [31:0] FBD_SECTOR_SIZE = 32'h0000_2000;
  typedef enum logic [1:0] {FBD_LOAD, FBD_RUN, FBD_WAIT} fbd_state_t;
endpackage
`default_nettype wire

// File: inc/fbd_cfg_if.sv
// Purpose: carries configuration-word fetches between the top and the loader
// Assumes: one fetch per cycle, word returned one cycle after its offset
// Notes: loader drives the offset, top returns the word
`default_nettype none
interface fbd_cfg_if;
  logic fetch;
  logic [31:0] ofs;
  logic [31:0] word;
  logic done;
  logic [31:0] prot;
  logic [31:0] supervisor_access_word;
  logic [31:0] data;
  logic [31:0] sec;
  modport loader (output fetch, output ofs, input word, output done, output prot, output supervisor_access_word,
    output data, output sec);
  modport top (input fetch, input ofs, output word, input done, input prot, input supervisor_access_word,
    input data, input sec);
endinterface
`default_nettype wire

// File: src/fbd_cfg_loader.sv
// Purpose: reads the configuration region once after reset
// Assumes: the flash word arrives one cycle after its offset, since the top registers the offset
// Notes: words land in fixed order protection, supervisor, data, security
`default_nettype none
module fbd_cfg_loader
  import fbd_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  fbd_cfg_if.loader cfg
);
  typedef struct packed {
    logic [2:0] idx;
    logic done;
    logic [3:0][31:0] w;
  } fbd_ld_t;
  fbd_ld_t s_q, s_d;

  // walk the four words from the protection word upward; each word answers
  // the fetch issued one cycle earlier, so slot idx-1 is filled
  always_comb begin
    s_d = s_q;
    if (!s_q.done) begin
      if (s_q.idx != 3'd0) begin
        s_d.w[2'(s_q.idx - 3'd1)] = cfg.word;
      end
      if (s_q.idx == 3'd4) begin
        s_d.done = 1'b1;
      end else begin
        s_d.idx = s_q.idx + 3'd1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q.idx <= 3'd0;
      s_q.done <= 1'b0;
      s_q.w <= {4{FBD_CFG_DEFAULT}};
    end else begin
      s_q <= s_d;
    end
  end

  assign cfg.fetch = !s_q.done && !s_q.idx[2];
  // the 8-byte key below the protection word is never fetched here
  assign cfg.ofs = FBD_CFG_PROT_OFS + {28'd0, s_q.idx[1:0], 2'b00};
  assign cfg.done = s_q.done;
  assign cfg.prot = s_q.w[0];
  assign cfg.supervisor_access_word = s_q.w[1];
  assign cfg.data = s_q.w[2];
  assign cfg.sec = s_q.w[3];
endmodule
`default_nettype wire

// File: tb/fbd_flash_model.sv
// Purpose: array side model feeding FLASH_RDATA
// Assumes: loader fetches only while cfg_ready is low
// Notes: protection and security words are chosen, the rest stay erased
`default_nettype none
module fbd_flash_model
  import fbd_pkg::*;
(
  input wire logic cfg_ready,
  input wire logic odd,
  input wire logic [17:0] word,
  input wire logic [31:0] cfg_word,
  input wire logic [31:0] cfg_addr,
  input wire logic [31:0] prot_word,
  output logic [31:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // config words follow the registered fetch offset
  always_comb begin
    if (!cfg_ready) begin
      rdata = FBD_CFG_DEFAULT;
      if (cfg_addr == FBD_CFG_PROT_OFS) begin
        rdata = prot_word;
      end
      if (cfg_addr == FBD_CFG_SEC_OFS) begin
        rdata = cfg_word;
      end
    end else begin
      rdata = {13'h1A5A, odd, word};
    end
  end
endmodule
`default_nettype wire

// File: tb/fbd_top_sva.sv
// Purpose: port checks for the flash base decode block
// Assumes: one clock, synchronous reset
// Notes: checks idle while reset is high
`default_nettype none
module fbd_top_sva
  import fbd_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic [31:0] REQ_ADDR,
  input wire logic [31:0] PERIPHERAL_BASE_REGISTER,
  input wire logic [31:0] DBG_RDATA,
  input wire logic FLASH_SEL,
  input wire logic FLASH_ODD,
  input wire logic FLASH_CFG_RD,
  input wire logic [31:0] FLASH_CFG_ADDR,
  input wire logic ACK,
  input wire logic ACCESS_ERR,
  input wire logic NON_FLASH,
  input wire logic PROT_VIOL,
  input wire logic CFG_READY
);
  timeunit 1ns;
  timeprecision 100ps;
  logic odd_q;
  logic back_q;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SRST);
  // address bit 2 and alias hit as seen on the request edge
  always_ff @(posedge CLK_SYS) begin
    odd_q <= REQ_ADDR[2];
    back_q <= (REQ_ADDR - (PERIPHERAL_BASE_REGISTER + FBD_BACKDOOR_OFS)) < FBD_BACKDOOR_SPAN;
  end
  err_with_ack_a: assert property (ACCESS_ERR |-> ACK) else $error("access error without ack");
  nonflash_ack_a: assert property (NON_FLASH |-> ACK) else $error("non-flash without ack");
  prot_with_ack_a: assert property (PROT_VIOL |-> ACK) else $error("protect flag without ack");
  odd_block_a: assert property (FLASH_SEL |-> FLASH_ODD == odd_q) else $error("wrong block");
  ready_holds_a: assert property (CFG_READY |=> CFG_READY) else $error("ready dropped");
  cfg_fetch_a: assert property (FLASH_CFG_RD |-> FLASH_CFG_ADDR inside {[FBD_CFG_PROT_OFS:FBD_CFG_SEC_OFS]})
    else $error("config fetch out of range");
  reserved_zero_a: assert property ((DBG_RDATA & ~FBD_DEFINED_BITS) == 32'h0) else $error("reserved bit set");
  direct_read_a: assert property (FLASH_SEL && !ACK && !back_q |=> ACK) else $error("direct read ack late");
  backdoor_wait_a: assert property (FLASH_SEL && !ACK && back_q |=> !ACK ##1 !ACK ##1 ACK)
    else $error("backdoor ack late");
  cover property (ACK && ACCESS_ERR);
  cover property (ACK && NON_FLASH);
  cover property (FLASH_SEL && !ACK);
endmodule
bind fbd_top fbd_top_sva fbd_top_sva_i (.CLK_SYS(CLK_SYS), .SRST(SRST), .REQ_ADDR(REQ_ADDR),
  .PERIPHERAL_BASE_REGISTER(PERIPHERAL_BASE_REGISTER),
  .DBG_RDATA(DBG_RDATA), .FLASH_SEL(FLASH_SEL), .FLASH_ODD(FLASH_ODD), .FLASH_CFG_RD(FLASH_CFG_RD),
  .FLASH_CFG_ADDR(FLASH_CFG_ADDR), .ACK(ACK), .ACCESS_ERR(ACCESS_ERR), .NON_FLASH(NON_FLASH),
  .PROT_VIOL(PROT_VIOL), .CFG_READY(CFG_READY));
`default_nettype wire

// File: tb/flash_base_address_decode_tb.sv
// Purpose: register and access sequences for the flash base decode block
// Assumes: inputs change on the falling edge
// Notes: array data comes back one cycle after the select (three through the backdoor alias) and is compared
`default_nettype none
module flash_base_address_decode_tb
  import fbd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK_SYS, SRST, CORE_CR_WR, DBG_WR, DBG_RD, RESET_CONFIG_PIN, REQ, REQ_WRITE, REQ_SUPERVISOR_ACCESS_WORD, REQ_CODE;
  logic REQ_IS_CORE, FLASH_SEL, FLASH_ODD, FLASH_WE, FLASH_CFG_RD, ACK, ACCESS_ERR, NON_FLASH, PROT_VIOL;
  logic SECURED, CFG_READY, REQ_PROG, REQ_CPU_SPACE;
  logic [31:0] CORE_CR_WDATA, DBG_WDATA, DBG_RDATA, REQ_ADDR, FLASH_RDATA, FLASH_CFG_ADDR, RDATA, cfg_word, v;
  logic [31:0] prot_word;
  logic [2:0] BOOT_DATA;
  logic [1:0] MASTER_MODE;
  logic [17:0] FLASH_WORD;
  logic [2:0] fl;
  int miscompares = 0;
  int checked = 0;
  int lat;
  localparam logic [31:0] PB = 32'h4000_0000;
  localparam logic [31:0] BD = PB + FBD_BACKDOOR_OFS;
  fbd_top fbd_top_i (.CLK_SYS(CLK_SYS), .SRST(SRST), .CORE_CR_WR(CORE_CR_WR), .CORE_CR_WDATA(CORE_CR_WDATA),
    .DBG_WR(DBG_WR), .DBG_RD(DBG_RD), .DBG_WDATA(DBG_WDATA), .DBG_RDATA(DBG_RDATA),
    .RESET_CONFIG_PIN(RESET_CONFIG_PIN), .BOOT_DATA(BOOT_DATA), .MASTER_MODE(MASTER_MODE),
    .PERIPHERAL_BASE_REGISTER(PB), .REQ(REQ), .REQ_ADDR(REQ_ADDR), .REQ_WRITE(REQ_WRITE), .REQ_PROG(REQ_PROG),
    .REQ_SUPERVISOR_ACCESS_WORD(REQ_SUPERVISOR_ACCESS_WORD), .REQ_CODE(REQ_CODE), .REQ_CPU_SPACE(REQ_CPU_SPACE), .REQ_IS_CORE(REQ_IS_CORE),
    .FLASH_RDATA(FLASH_RDATA), .FLASH_SEL(FLASH_SEL), .FLASH_ODD(FLASH_ODD), .FLASH_WORD(FLASH_WORD),
    .FLASH_WE(FLASH_WE), .FLASH_CFG_RD(FLASH_CFG_RD), .FLASH_CFG_ADDR(FLASH_CFG_ADDR), .ACK(ACK),
    .RDATA(RDATA), .ACCESS_ERR(ACCESS_ERR), .NON_FLASH(NON_FLASH), .PROT_VIOL(PROT_VIOL),
    .SECURED(SECURED), .CFG_READY(CFG_READY));
  fbd_flash_model fbd_flash_model_i (.cfg_ready(CFG_READY), .odd(FLASH_ODD), .word(FLASH_WORD),
    .cfg_word(cfg_word), .cfg_addr(FLASH_CFG_ADDR), .prot_word(prot_word), .rdata(FLASH_RDATA));
  task automatic give_verdict();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // strobe pulses last one cycle; the read waits one spare cycle since data holds
  task automatic wr(input bit core, input logic [31:0] d);
    @(negedge CLK_SYS);
    CORE_CR_WR = core;
    DBG_WR = !core;
    CORE_CR_WDATA = d;
    DBG_WDATA = d;
    @(negedge CLK_SYS);
    CORE_CR_WR = 0;
    DBG_WR = 0;
  endtask
  task automatic rd();
    @(negedge CLK_SYS);
    DBG_RD = 1;
    @(negedge CLK_SYS);
    DBG_RD = 0;
    @(negedge CLK_SYS);
    v = DBG_RDATA;
  endtask
  task automatic strap(input logic rc, input logic [2:0] bd, input logic [1:0] mm, input logic [31:0] sw,
    input logic exp);
    int n;
    SRST = 1;
    RESET_CONFIG_PIN = rc;
    BOOT_DATA = bd;
    MASTER_MODE = mm;
    cfg_word = sw;
    repeat (4) @(negedge CLK_SYS);
    SRST = 0;
    n = 0;
    while (CFG_READY !== 1'b1) begin
      @(negedge CLK_SYS);
      n++;
      if (n > 20) begin
        miscompares++;
        give_verdict();
      end
    end
    rd();
    chk(v, {31'h0, exp});
    chk(SECURED, {31'h0, sw != FBD_SEC_OPEN});
  endtask
  // qualifiers stay put until the next request, after the ack
  task automatic acc(input logic [31:0] a, input logic w, input logic s, input logic c, input logic core);
    @(negedge CLK_SYS);
    REQ = 1;
    REQ_ADDR = a;
    REQ_WRITE = w;
    REQ_SUPERVISOR_ACCESS_WORD = s;
    REQ_CODE = c;
    REQ_IS_CORE = core;
    @(negedge CLK_SYS);
    REQ = 0;
    lat = 1;
    while (ACK !== 1'b1) begin
      @(negedge CLK_SYS);
      lat++;
      if (lat > 8) begin
        miscompares++;
        give_verdict();
      end
    end
    fl = {ACCESS_ERR, NON_FLASH, PROT_VIOL};
  endtask
  initial begin
    CLK_SYS = 0;
    forever #12.5 CLK_SYS = ~CLK_SYS;
  end
  initial begin
    {CORE_CR_WR, DBG_WR, DBG_RD, REQ, REQ_WRITE, REQ_SUPERVISOR_ACCESS_WORD, REQ_CODE, REQ_IS_CORE, REQ_PROG, REQ_CPU_SPACE} = '0;
    {CORE_CR_WDATA, DBG_WDATA, REQ_ADDR} = '0;
    prot_word = FBD_CFG_DEFAULT;
    strap(1, 3'h6, 2'h3, FBD_CFG_DEFAULT, 1);
    strap(1, 3'h7, 2'h0, FBD_CFG_DEFAULT, 1);
    strap(1, 3'h7, 2'h1, FBD_CFG_DEFAULT, 0);
    strap(1, 3'h7, 2'h1, 32'h0000_0000, 1);
    prot_word = 32'hFFFF_FFFE;
    strap(0, 3'h0, 2'h0, FBD_CFG_DEFAULT, 1);
    wr(0, 32'hFFFF_FFFF);
    rd();
    chk(v, FBD_DEFINED_BITS);
    wr(1, 32'h0008_0001);
    rd();
    chk(v, 32'h0008_0001);
    acc(32'h0008_0004, 0, 1, 0, 1);
    chk(FLASH_ODD, 1);
    chk({lat[28:0], fl}, {29'd2, 3'b000});
    chk(RDATA, {13'h1A5A, 1'b1, 18'h0_0001});
    acc(32'h000B_FFF8, 0, 1, 1, 1);
    chk({lat[28:0], fl}, {29'd2, 3'b000});
    chk(RDATA, {13'h1A5A, 1'b0, 18'h0_FFFE});
    acc(32'h0010_0000, 0, 1, 0, 1);
    chk(fl, 3'b010);
    acc(BD + 32'h0000_000C, 0, 1, 0, 0);
    chk({lat[28:0], fl}, {29'd4, 3'b000});
    chk(RDATA, {13'h1A5A, 1'b1, 18'h0_0003});
    acc(32'h0008_0000, 0, 1, 0, 0);
    chk(fl, 3'b010);
    acc(BD + 32'h0000_0010, 1, 1, 0, 1);
    chk({lat[28:0], fl}, {29'd1, 3'b000});
    chk(FLASH_WE, 1);
    chk({14'h0, FLASH_WORD}, 32'h0000_0004);
    REQ_PROG = 1;
    acc(BD, 1, 1, 0, 1);
    chk(fl, 3'b001);
    acc(BD + 32'h0000_2000, 1, 1, 0, 1);
    chk(fl, 3'b000);
    REQ_PROG = 0;
    wr(1, 32'h0008_0101);
    acc(BD + 32'h0000_0010, 1, 1, 0, 1);
    chk(fl, 3'b100);
    wr(1, 32'h0008_0003);
    acc(32'h0008_0000, 0, 0, 0, 1);
    chk(fl, 3'b010);
    acc(32'h0008_0000, 0, 1, 0, 1);
    chk(fl, 3'b000);
    wr(1, 32'h0008_0021);
    REQ_CPU_SPACE = 1;
    acc(32'h0008_0000, 0, 1, 0, 1);
    chk(fl, 3'b010);
    REQ_CPU_SPACE = 0;
    wr(1, 32'h0008_0000);
    acc(32'h0008_0000, 0, 1, 0, 1);
    chk(fl, 3'b010);
    give_verdict();
  end
endmodule
`default_nettype wire
